// ===== rtl/smbus_host_pkg.sv
// smbus host package: register map, field positions, timing and shared types
// assumes a 250 mhz system clock and a 100 khz two-wire bus
`default_nettype none
package smbus_host_pkg;
  // clock and bus timing
  localparam int CLK_KHZ = 250000;
  localparam int BUS_KHZ = 100;
  localparam int QTR_CYC = CLK_KHZ / (4 * BUS_KHZ); // quarter bit period, rounded down
  localparam int QTR_NS = 1000000 / (4 * BUS_KHZ);
  localparam int BUS_FREE_NS = 4700;
  localparam int GAP_QTRS = (BUS_FREE_NS + QTR_NS - 1) / QTR_NS; // idle gap, rounded up
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  localparam int BUF_BYTES = 32;
  localparam logic [5:0] CNT_ONE = 6'h01;
  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h02;
  localparam logic [7:0] OFS_COMMAND = 8'h03;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_FIRST_DATA_REG = 8'h05;
  localparam logic [7:0] OFS_SECOND_DATA_REG = 8'h06;
  localparam logic [7:0] OFS_BLOCK = 8'h07;
  localparam logic [7:0] OFS_AUX = 8'h0d;
  // field positions
  localparam int ST_BUSY_B = 0;
  localparam int ST_DONE_B = 1;
  localparam int ST_DEVERR_B = 2;
  localparam int ST_COLL_B = 3;
  localparam int ST_BYTE_B = 7;
  localparam int CTL_CMD_LSB = 2;
  localparam int CTL_START_B = 6;
  localparam int CTL_PEC_B = 7;
  localparam logic [7:0] CTL_WR_MASK = 8'hbf; // start bit is never stored
  localparam int AUX_CRC_B = 0;
  localparam int AUX_BUF_B = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // command selections in the control register
  localparam logic [2:0] CMD_BLOCK = 3'h5;
  localparam logic [2:0] CMD_I2C_READ = 3'h6;
  localparam logic [2:0] CMD_BLOCK_PROC = 3'h7;
  ////////////////////////////////////////////////////////////////////////
  // register access request from the i/o decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // open-drain pull-down enables
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } line_drive_t;
  // bus engine states
  typedef enum logic [5:0] {
    E_IDLE = 6'b000001,
    E_START = 6'b000010,
    E_SEND = 6'b000100,
    E_RECV = 6'b001000,
    E_STOP = 6'b010000,
    E_HOLD = 6'b100000
  } eng_state_t;
  // message steps
  typedef enum logic [6:0] {
    P_ADDR1 = 7'b0000001,
    P_CMD = 7'b0000010,
    P_WCNT = 7'b0000100,
    P_WDATA = 7'b0001000,
    P_ADDR2 = 7'b0010000,
    P_RCNT = 7'b0100000,
    P_RDATA = 7'b1000000
  } msg_step_t;
endpackage
`default_nettype wire

// ===== rtl/block_buffer_mem.sv
// block data buffer: one write port, one registered read port
// assumes both ports run on the same clock
`default_nettype none
module block_buffer_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic clk_sys,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array; read data only valid after a write
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, one cycle behind the address
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== rtl/smbus_block_host.sv
// smbus host block engine: block write/read, two-wire block read, process call
// assumes register requests arrive on clk_sys; scl/sda are open-drain pins
// Functional notes
// - 32-byte buffer used only when auxiliary control bit 1 is set
// - completion flagged only when the full programmed count is done
// - byte count is sent but never ends the transfer
// - block write sends address, command, count, then count bytes of block data
// - block read keeps first byte in first data, rest in block data
// - two-wire mode block write omits the count byte, still sends count bytes
// - two-wire mode always bypasses the buffer
// - two-wire read: address write, second data, repeated start, address read, data
// - two-wire read receives until the host not-acknowledge, then stop
// - two-wire read uses 7-bit addresses, works in either mode
// - process call counts each at least one, sum at most 32
// - process call writes M bytes, repeated start, reads count and N bytes
// - packet error code excluded from read count; recommended by software
// - reading host control resets the buffer pointer
// - data released high but sampled low means collision, stop at once
// - host drives clock, meets start/stop timing, keeps idle gap
// - high-time counter held while released clock stays low
// - stuck clock or missing answer abandons transfer with device error
// - timeout counts while awaiting answer, paused by byte done or watchdog clear
// - quarter-bit timing gives a 100 khz bus clock
// - busy while running, done on success, device error on no acknowledge
`default_nettype none
module smbus_block_host
  import smbus_host_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int BUF_DEPTH = BUF_BYTES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register access
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // same-clock configuration and watchdog state
  input wire logic two_wire_mode_enable,
  input wire logic second_watchdog_timeout_flag,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output var line_drive_t drv
);
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int QW = $clog2(QTR_CYC);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  // refuse sizes the pointers and counters cannot serve
  // the timeout also runs through the acknowledge bit of every sent byte, so it must outlast one bit time
  if (BUF_DEPTH < BUF_BYTES || (1 << PW) != BUF_DEPTH || TIMEOUT_CYCLES <= 4 * QTR_CYC
      || QTR_CYC < 4) begin : g_check
    $error("unsupported buffer depth or timing");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [1:0] scl_ff_r, sda_ff_r;
  logic scl_s, sda_s;
  eng_state_t state_r;
  msg_step_t step_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [5:0] left_r;
  logic [PW-1:0] eng_ptr_r, sw_ptr_r;
  logic [7:0] tx_sh_r, rx_sh_r, tx_src, tx_cur;
  logic ack_ok_r, tx_bit, nak_now, stall, qtick, adv, go, busy;
  logic [QW-1:0] qcnt_r;
  logic [TW-1:0] tmo_r;
  logic tmo_run, tmo_hit;
  logic [2:0] gap_r;
  logic [2:0] proto_r;
  logic rd_dir_r, twm_r, bufm_r;
  logic evt_done_r, evt_err_r, evt_coll_r, evt_byte_r, evt_d0_r, evt_rx_r;
  logic done_r, deverr_r, coll_r, bytedone_r;
  logic [7:0] ctl_r, cmd_r, taddr_r, first_data_reg_r, second_data_reg_r, aux_r, blk_byte_r, rdata_r;
  logic st_wr, ctl_wr, blk_wr, blk_rd, sw_buf;
  logic mem_we;
  logic [PW-1:0] mem_wa, mem_ra;
  logic [7:0] mem_wd, mem_q;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; open drain so the driven level is always low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_ff_r <= 2'b11;
      sda_ff_r <= 2'b11;
    end else begin
      scl_ff_r <= {scl_ff_r[0], scl_in};
      sda_ff_r <= {sda_ff_r[0], sda_in};
    end
  end
  assign scl_s = scl_ff_r[1];
  assign sda_s = sda_ff_r[1];
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // quarter-bit timer; held at zero while the released clock reads low
  assign busy = (state_r != E_IDLE);
  assign stall = (ph_r == 2'd2) && !scl_s && busy && (state_r != E_HOLD);
  assign qtick = (qcnt_r == QW'(QTR_CYC - 1));
  assign adv = qtick && busy && (state_r != E_HOLD);

  always_ff @(posedge clk_sys) begin
    if (reset || !busy || stall || state_r == E_HOLD || qtick) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus timeout: runs while the clock is stretched or the acknowledge is awaited
  assign tmo_run = (stall || (state_r == E_SEND && bit_r == 4'd8))
                   && !bytedone_r && second_watchdog_timeout_flag;
  assign tmo_hit = (tmo_r == TW'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (reset || !busy) begin
      tmo_r <= '0;
    end else if (!stall && !(state_r == E_SEND && bit_r == 4'd8)) begin
      tmo_r <= '0;
    end else if (tmo_run) begin
      tmo_r <= tmo_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte to send for the current step
  always_comb begin
    unique case (step_r)
      P_ADDR1: tx_src = {taddr_r[7:1], 1'b0};
      P_CMD: tx_src = (proto_r == CMD_I2C_READ) ? second_data_reg_r : cmd_r;
      P_WCNT: tx_src = first_data_reg_r;
      P_WDATA: tx_src = bufm_r ? mem_q : blk_byte_r;
      P_ADDR2: tx_src = {taddr_r[7:1], 1'b1};
      default: tx_src = 8'hff;
    endcase
  end
  assign tx_cur = (bit_r == 4'd0) ? tx_src : tx_sh_r;
  assign tx_bit = tx_cur[7];
  assign nak_now = (step_r == P_RDATA) && (left_r == CNT_ONE);

  // a start is only taken for the block commands and only when idle
  assign go = ctl_wr && req.wdata[CTL_START_B] && !busy
              && (req.wdata[CTL_CMD_LSB +: 3] == CMD_BLOCK || req.wdata[CTL_CMD_LSB +: 3] == CMD_I2C_READ
                  || req.wdata[CTL_CMD_LSB +: 3] == CMD_BLOCK_PROC);

  ////////////////////////////////////////////////////////////////////////
  // mode latched at start so mid-command register writes cannot change it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      proto_r <= CMD_BLOCK;
      rd_dir_r <= 1'b0;
      twm_r <= 1'b0;
      bufm_r <= 1'b0;
    end else if (go) begin
      proto_r <= req.wdata[CTL_CMD_LSB +: 3];
      rd_dir_r <= taddr_r[0];
      twm_r <= two_wire_mode_enable;
      bufm_r <= aux_r[AUX_BUF_B] && !two_wire_mode_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus engine: four quarters per bit, nine bits per byte
  always_ff @(posedge clk_sys) begin
    evt_done_r <= 1'b0;
    evt_err_r <= 1'b0;
    evt_coll_r <= 1'b0;
    evt_byte_r <= 1'b0;
    evt_d0_r <= 1'b0;
    evt_rx_r <= 1'b0;
    if (reset) begin
      state_r <= E_IDLE;
      step_r <= P_ADDR1;
      ph_r <= 2'd0;
      bit_r <= 4'd0;
      left_r <= '0;
      eng_ptr_r <= '0;
      tx_sh_r <= RESET_BYTE;
      rx_sh_r <= RESET_BYTE;
      ack_ok_r <= 1'b0;
      gap_r <= '0;
      drv <= '0;
    end else if (go) begin
      state_r <= E_START;
      step_r <= P_ADDR1;
      ph_r <= 2'd0;
      bit_r <= 4'd0;
      gap_r <= '0;
      eng_ptr_r <= '0;
      left_r <= first_data_reg_r[5:0];
    end else if (tmo_hit) begin
      drv <= '0;
      state_r <= E_IDLE;
      evt_err_r <= 1'b1;
    end else begin
      if (evt_rx_r && bufm_r) begin
        eng_ptr_r <= eng_ptr_r + 1'b1;
      end
      if (state_r == E_HOLD && !bytedone_r) begin
        // software has serviced the single byte, resume the next one
        state_r <= (step_r == P_RDATA) ? E_RECV : E_SEND;
        ph_r <= 2'd0;
        bit_r <= 4'd0;
      end else if (adv) begin
        ph_r <= ph_r + 1'b1;
        unique case (ph_r)
          2'd0: begin
            // set data mid-way through clock low
            if (state_r == E_START) drv.sda_oe <= 1'b0;
            else if (state_r == E_STOP) drv.sda_oe <= 1'b1;
            else if (state_r == E_SEND) drv.sda_oe <= (bit_r != 4'd8) && !tx_bit;
            else drv.sda_oe <= (bit_r == 4'd8) && !nak_now;
          end
          2'd1: drv.scl_oe <= 1'b0;
          2'd2: begin
            // clock has been seen high for a full quarter here
            if (state_r == E_START) begin
              drv.sda_oe <= 1'b1;
            end else if (state_r == E_STOP) begin
              drv.sda_oe <= 1'b0;
            end else if (state_r == E_SEND && bit_r != 4'd8) begin
              tx_sh_r <= {tx_cur[6:0], 1'b0};
              if (tx_bit && !sda_s) begin
                drv <= '0;
                state_r <= E_IDLE;
                evt_coll_r <= 1'b1;
              end
            end else if (state_r == E_SEND) begin
              ack_ok_r <= !sda_s;
            end else if (bit_r != 4'd8) begin
              rx_sh_r <= {rx_sh_r[6:0], sda_s};
            end
          end
          2'd3: begin
            if (state_r == E_STOP) begin
              // bus free gap before the next transaction may start
              ph_r <= 2'd3;
              gap_r <= gap_r + 1'b1;
              if (gap_r == 3'(GAP_QTRS - 1)) begin
                state_r <= E_IDLE;
                ph_r <= 2'd0;
              end
            end else if (state_r == E_START) begin
              drv.scl_oe <= 1'b1;
              state_r <= E_SEND;
            end else if (bit_r != 4'd8) begin
              drv.scl_oe <= 1'b1;
              bit_r <= bit_r + 1'b1;
            end else begin
              drv.scl_oe <= 1'b1;
              bit_r <= 4'd0;
              if (state_r == E_SEND && !ack_ok_r) begin
                state_r <= E_STOP;
                evt_err_r <= 1'b1;
              end else begin
                unique case (step_r)
                  P_ADDR1: step_r <= P_CMD;
                  P_CMD: begin
                    if (proto_r == CMD_BLOCK && !rd_dir_r) begin
                      step_r <= twm_r ? P_WDATA : P_WCNT;
                    end else if (proto_r == CMD_BLOCK_PROC) begin
                      step_r <= P_WCNT;
                    end else begin
                      state_r <= E_START;
                      step_r <= P_ADDR2;
                    end
                  end
                  P_WCNT: step_r <= P_WDATA;
                  P_WDATA: begin
                    left_r <= left_r - 1'b1;
                    eng_ptr_r <= eng_ptr_r + 1'b1;
                    if (left_r == CNT_ONE) begin
                      if (proto_r == CMD_BLOCK_PROC) begin
                        state_r <= E_START;
                        step_r <= P_ADDR2;
                      end else begin
                        state_r <= E_STOP;
                        evt_done_r <= 1'b1;
                      end
                    end else if (!bufm_r) begin
                      state_r <= E_HOLD;
                      evt_byte_r <= 1'b1;
                    end
                  end
                  P_ADDR2: begin
                    state_r <= E_RECV;
                    step_r <= (proto_r == CMD_I2C_READ) ? P_RDATA : P_RCNT;
                    if (proto_r == CMD_BLOCK_PROC) left_r <= second_data_reg_r[5:0];
                  end
                  P_RCNT: begin
                    step_r <= P_RDATA;
                    evt_d0_r <= 1'b1;
                  end
                  P_RDATA: begin
                    left_r <= left_r - 1'b1;
                    evt_rx_r <= 1'b1;
                    if (left_r == CNT_ONE) begin
                      state_r <= E_STOP;
                      evt_done_r <= 1'b1;
                    end else if (!bufm_r) begin
                      state_r <= E_HOLD;
                      evt_byte_r <= 1'b1;
                    end
                  end
                  default: state_r <= E_STOP;
                endcase
              end
            end
          end
          default: ph_r <= 2'd0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register write decode
  assign st_wr = req.wr && (req.addr == OFS_STATUS);
  assign ctl_wr = req.wr && (req.addr == OFS_CONTROL);
  assign blk_wr = req.wr && (req.addr == OFS_BLOCK);
  assign blk_rd = req.rd && (req.addr == OFS_BLOCK);
  assign sw_buf = aux_r[AUX_BUF_B] && !two_wire_mode_enable;

  // plain software registers; engine updates first data and single byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_r <= RESET_BYTE;
      cmd_r <= RESET_BYTE;
      taddr_r <= RESET_BYTE;
      first_data_reg_r <= RESET_BYTE;
      second_data_reg_r <= RESET_BYTE;
      aux_r <= RESET_BYTE;
      blk_byte_r <= RESET_BYTE;
    end else begin
      if (ctl_wr) ctl_r <= req.wdata & CTL_WR_MASK;
      if (req.wr && req.addr == OFS_COMMAND) cmd_r <= req.wdata;
      if (req.wr && req.addr == OFS_TARGET) taddr_r <= req.wdata;
      if (req.wr && req.addr == OFS_SECOND_DATA_REG) second_data_reg_r <= req.wdata;
      if (req.wr && req.addr == OFS_AUX) aux_r <= req.wdata;
      if (evt_d0_r) first_data_reg_r <= rx_sh_r;
      else if (req.wr && req.addr == OFS_FIRST_DATA_REG) first_data_reg_r <= req.wdata;
      if (evt_rx_r && !bufm_r) blk_byte_r <= rx_sh_r;
      else if (blk_wr && !sw_buf) blk_byte_r <= req.wdata;
    end
  end

  // status flags: hardware set wins over software write-one-to-clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      done_r <= 1'b0;
      deverr_r <= 1'b0;
      coll_r <= 1'b0;
      bytedone_r <= 1'b0;
    end else begin
      done_r <= evt_done_r || (done_r && !(st_wr && req.wdata[ST_DONE_B]));
      deverr_r <= evt_err_r || (deverr_r && !(st_wr && req.wdata[ST_DEVERR_B]));
      coll_r <= evt_coll_r || (coll_r && !(st_wr && req.wdata[ST_COLL_B]));
      bytedone_r <= evt_byte_r || (bytedone_r && !(st_wr && req.wdata[ST_BYTE_B]) && !go);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software buffer pointer, cleared by any read of host control
  always_ff @(posedge clk_sys) begin
    if (reset || (req.rd && req.addr == OFS_CONTROL)) begin
      sw_ptr_r <= '0;
    end else if ((blk_wr || blk_rd) && sw_buf) begin
      sw_ptr_r <= sw_ptr_r + 1'b1;
    end
  end

  // engine owns the buffer while busy; software fills or drains it otherwise
  assign mem_we = (evt_rx_r && bufm_r) || (blk_wr && sw_buf && !busy);
  assign mem_wa = evt_rx_r ? eng_ptr_r : sw_ptr_r;
  assign mem_wd = evt_rx_r ? rx_sh_r : req.wdata;
  assign mem_ra = busy ? eng_ptr_r : sw_ptr_r;

  block_buffer_mem #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH),
    .AW(PW)
  ) u_buf (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(mem_ra),
    .rd_data(mem_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // registered read data; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= RESET_BYTE;
    end else if (req.rd) begin
      case (req.addr)
        OFS_STATUS: begin
          rdata_r <= RESET_BYTE;
          rdata_r[ST_BUSY_B] <= busy;
          rdata_r[ST_DONE_B] <= done_r;
          rdata_r[ST_DEVERR_B] <= deverr_r;
          rdata_r[ST_COLL_B] <= coll_r;
          rdata_r[ST_BYTE_B] <= bytedone_r;
        end
        OFS_CONTROL: rdata_r <= ctl_r;
        OFS_COMMAND: rdata_r <= cmd_r;
        OFS_TARGET: rdata_r <= taddr_r;
        OFS_FIRST_DATA_REG: rdata_r <= first_data_reg_r;
        OFS_SECOND_DATA_REG: rdata_r <= second_data_reg_r;
        OFS_BLOCK: rdata_r <= sw_buf ? mem_q : blk_byte_r;
        OFS_AUX: rdata_r <= aux_r;
        default: rdata_r <= RESET_BYTE;
      endcase
    end
  end
  assign rdata = rdata_r;
endmodule
`default_nettype wire

// ===== sim/smbus_host_asserts.sv
// port checker for the smbus block host
// assumes one clock domain, bound onto the host
`default_nettype none
module smbus_host_asserts
  import smbus_host_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register side
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  // configuration
  input wire logic two_wire_mode_enable,
  input wire logic second_watchdog_timeout_flag,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire line_drive_t drv
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP_CYC = GAP_QTRS * QTR_CYC - 4; // slack for the synchronisers
  localparam int LOW_MIN = 2 * QTR_CYC - 2;
  localparam int GO_MAX = 4 * QTR_CYC; // start condition lands within one bit time
  int lo_cnt;
  int gap_cnt;
  int go_cnt;
  // length of the current scl pull
  always_ff @(posedge clk_sys) begin
    lo_cnt <= drv.scl_oe ? lo_cnt + 1 : 0;
  end
  // idle gap opens at a stop: sda let go while scl is high
  always_ff @(posedge clk_sys) begin
    if (reset) gap_cnt <= 0;
    else if ($fell(drv.sda_oe) && scl_in) gap_cnt <= 1;
    else if (gap_cnt != 0 && gap_cnt < GAP_CYC) gap_cnt <= gap_cnt + 1;
    else gap_cnt <= 0;
  end
  // cycles from a start write until the start condition pulls sda; too long for a delay range
  always_ff @(posedge clk_sys) begin
    if (reset || drv.sda_oe) go_cnt <= 0;
    else if (req.wr && req.addr == OFS_CONTROL && req.wdata[CTL_START_B]
             && req.wdata[4:2] >= CMD_BLOCK) go_cnt <= 1;
    else if (go_cnt != 0) go_cnt <= go_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_od; scl_out == 1'b0 && sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_go; go_cnt <= GO_MAX; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_hold; $rose(drv.sda_oe) && !drv.scl_oe |=> !drv.scl_oe [*8]; endproperty
  a_hold: assert property (p_hold) else $error("start hold short");
  property p_low; $fell(drv.scl_oe) |-> lo_cnt >= LOW_MIN; endproperty
  a_low: assert property (p_low) else $error("scl low short");
  property p_str; !drv.scl_oe && !scl_in |=> !drv.scl_oe; endproperty
  a_str: assert property (p_str) else $error("stretch ignored");
  property p_gap; gap_cnt != 0 |-> !drv.sda_oe && !drv.scl_oe; endproperty
  a_gap: assert property (p_gap) else $error("idle gap short");
  property p_busy; req.rd && req.addr == OFS_STATUS && drv.scl_oe |=> rdata[ST_BUSY_B]; endproperty
  a_busy: assert property (p_busy) else $error("busy low");
  property p_aux; (req.wr && req.addr == OFS_AUX) ##2 (req.rd && req.addr == OFS_AUX)
    |=> (rdata & 8'h03) == ($past(req.wdata, 3) & 8'h03); endproperty
  a_aux: assert property (p_aux) else $error("aux readback");
  c_str: cover property (!drv.scl_oe && !scl_in);
  c_stop: cover property (gap_cnt == 1);
  c_go: cover property ($rose(drv.sda_oe) && scl_in);
endmodule
bind smbus_block_host smbus_host_asserts smbus_host_asserts_i (
  .clk_sys(clk_sys), .reset(reset), .req(req), .rdata(rdata), .two_wire_mode_enable(two_wire_mode_enable),
  .second_watchdog_timeout_flag(second_watchdog_timeout_flag), .scl_in(scl_in), .sda_in(sda_in),
  .scl_out(scl_out), .sda_out(sda_out), .drv(drv)
);
`default_nettype wire

// ===== sim/smbus_target_model.sv
// target model: acks each byte, may stretch scl or collide on sda
// assumes wired-and lines with pull-ups made by the bench
`default_nettype none
module smbus_target_model (
  // clock
  input wire logic clk_sys,
  // line levels and controls
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  input wire logic collide,
  // pull-downs and capture
  output logic scl_oe = 1'b0,
  output wire logic sda_oe,
  output logic [7:0] last_byte = 8'h00,
  output logic [7:0] nbytes = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic ack_r = 1'b0;
  logic col_r = 1'b0;
  logic [3:0] bitn = 4'h0;
  logic [7:0] sh = 8'h00;
  // collide pull drops at once so the next start is not blocked
  assign sda_oe = ack_r || (col_r && collide);
  ////////////////////////////////////////////////////////////////////////
  // edges found by sampling; ack held over the ninth bit
  always @(posedge clk_sys) begin
    scl_q <= scl;
    sda_q <= sda;
    scl_oe <= stretch && (scl_oe || !scl);
    if (scl_q && scl && sda_q && !sda) begin
      bitn <= 4'h0;
    end else if (!scl_q && scl) begin
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      sh <= {sh[6:0], sda};
      if (bitn == 4'h7) begin
        last_byte <= {sh[6:0], sda};
        nbytes <= nbytes + 8'h01;
      end
    end else if (scl_q && !scl) begin
      ack_r <= (bitn == 4'h8);
      col_r <= collide;
    end
  end
endmodule
`default_nettype wire

// ===== sim/smbus_block_host_bench.sv
// bench for the smbus block host: register tasks and bus scenarios
// assumes the target model on open-drain lines with pull-ups
`default_nettype none
module smbus_block_host_bench
  import smbus_host_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic twm = 1'b0;
  logic wdog = 1'b1;
  logic stretch = 1'b0;
  logic collide = 1'b0;
  logic t_scl_oe;
  logic t_sda_oe;
  logic [7:0] last_byte;
  logic [7:0] nbytes;
  logic [7:0] n0;
  line_drive_t drv;
  int fails = 0;
  int checks_done = 0;
  // wired-and lines with pull-ups
  wire scl = !(drv.scl_oe || t_scl_oe);
  wire sda = !(drv.sda_oe || t_sda_oe);
  always #2 clk_sys = ~clk_sys;
  // short timeout keeps the stuck-clock case brief, yet outlasts a whole acknowledge bit
  smbus_block_host #(.TIMEOUT_CYCLES(5000)) smbus_block_host_i (
    .clk_sys(clk_sys), .reset(reset), .req(req), .rdata(rdata), .two_wire_mode_enable(twm),
    .second_watchdog_timeout_flag(wdog), .scl_in(scl), .sda_in(sda), .scl_out(), .sda_out(), .drv(drv)
  );
  smbus_target_model smbus_target_model_i (
    .clk_sys(clk_sys), .scl(scl), .sda(sda), .stretch(stretch), .collide(collide),
    .scl_oe(t_scl_oe), .sda_oe(t_sda_oe), .last_byte(last_byte), .nbytes(nbytes)
  );
  ////////////////////////////////////////////////////////////////////////
  // register access: one strobe cycle, then one quiet cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
    d = rdata;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmp(d, e);
  endtask
  // start a block command, wait for busy to fall, check and clear flags
  task automatic run(input logic [7:0] flags);
    logic [7:0] d;
    wr(OFS_CONTROL, 8'h54);
    rd(OFS_STATUS, d);
    cmp(d & 8'h01, 8'h01);
    for (int i = 0; i < 40000 && d[0] !== 1'b0; i++) rd(OFS_STATUS, d);
    repeat (4) @(posedge clk_sys);
    rd(OFS_STATUS, d);
    cmp(d & 8'h0f, flags);
    wr(OFS_STATUS, 8'h8e);
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk(OFS_STATUS, 8'h00);
    chk(OFS_CONTROL, 8'h00);
    wr(OFS_AUX, 8'h03);
    chk(OFS_AUX, 8'h03);
    chk(8'h3f, 8'h00);
    wr(OFS_AUX, 8'h00);
    wr(OFS_TARGET, 8'ha0);
    wr(OFS_COMMAND, 8'h3c);
    collide <= 1'b1;
    run(8'h08);
    collide <= 1'b0;
    stretch <= 1'b1;
    run(8'h04);
    stretch <= 1'b0;
    // two-wire write of one byte: address, command, data only
    twm <= 1'b1;
    wr(OFS_FIRST_DATA_REG, 8'h01);
    wr(OFS_BLOCK, 8'hd5);
    n0 = nbytes;
    run(8'h02);
    cmp(nbytes - n0, 8'h03);
    cmp(last_byte, 8'hd5);
    conclude();
  end
  // hang guard, past the roughly 85000 cycles the three transfers need
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
